// [design/qls_ctrl.sv]
/*
 * Quad link status and test control: read-clearing channel event status,
 * alignment / receive FIFO status, power-down, loopback, multifunction pin
 * and power-on reset gating of the receive parallel outputs.
 * Assumes event inputs are single-cycle pulses on sys_clk_i from the data
 * path; enable and loopback pins are asynchronous; config bits are static.
 */
`timescale 1ns/100ps
`include "qls_consts.svh"

module qls_ctrl #(
    parameter int unsigned POR_CYCLES = `QLS_POR_CYCLES,
    parameter int unsigned NUM_CH     = 4
) (
    input  wire logic                  sys_clk_i,            // Reference clock
    input  wire logic                  rst_i,                // Power not valid
    input  wire logic                  enable_i,             // Device enable pin
    input  wire logic [NUM_CH-1:0]     loop_path_enable_n_i, // Loopback pins, low active
    input  wire logic [NUM_CH-1:0]     cfg_loopback_i,       // Per-channel loopback bit
    input  wire logic                  global_loopback_i,    // Global loopback bit
    input  wire logic [2*NUM_CH-1:0]   mf_sel_i,             // Multifunction select pairs
    input  wire logic                  io_std_i,             // Output standard indicator
    input  wire logic [NUM_CH-1:0]     comma_det_i,          // Comma detected per channel
    input  wire logic [NUM_CH-1:0]     tx_fifo_coll_i,       // Tx FIFO collision pulse
    input  wire logic [NUM_CH-1:0]     decode_err_i,         // Decode error pulse
    input  wire logic [NUM_CH-1:0]     prbs_err_i,           // PRBS checker error pulse
    input  wire logic [NUM_CH-1:0]     carrier_absent_i,     // Carrier lost pulse
    input  wire logic                  align_seen_i,         // Alignment on all channels
    input  wire logic [NUM_CH-1:0]     rx_fifo_coll_i,       // Rx FIFO collision pulse
    input  wire logic                  reg_rd_i,             // Register read strobe
    input  wire logic [`QLS_ADDR_W-1:0] reg_addr_i,          // Register number
    output logic      [15:0]           reg_rdata_o,          // Read data
    output logic                       reg_rvalid_o,         // Read data valid
    output logic                       digital_en_o,         // Digital logic enabled
    output logic      [NUM_CH-1:0]     loopback_o,           // Internal loopback active
    output logic      [NUM_CH-1:0]     tx_serial_oe_o,       // Serial output driven
    output logic                       rx_data_oe_o,         // Parallel rx data driven
    output logic      [NUM_CH-1:0]     rx_word_clock_en_o,   // Word clock runs
    output logic      [NUM_CH-1:0]     multifunction_output_o // Multifunction pins
);
    import qls_pkg::*;

    qls_state_t s_q;
    qls_state_t s_d;
    logic       por_active;
    logic       live;
    logic       rd_ev;
    logic       rd_al;

    // ======================================================================
    // Power-on reset
    qls_por #(
        .POR_CYCLES (POR_CYCLES)
    ) u_por (
        .sys_clk_i    (sys_clk_i),
        .rst_i        (rst_i),
        .por_active_o (por_active)
    );

    // Events only count while powered and out of reset
    assign live  = s_q.en && !por_active;
    assign rd_ev = reg_rd_i && (reg_addr_i == `QLS_OFS_EVENT_STATUS);
    assign rd_al = reg_rd_i && (reg_addr_i == `QLS_OFS_ALIGN_STATUS);

    function automatic logic [3:0] rc_flag(input logic [3:0] cur, input logic [3:0] ev,
                                           input logic rd, input logic act);
        // Set beats the read-clear so a coincident event survives
        rc_flag = ((rd ? 4'h0 : cur) | (act ? ev : 4'h0));
    endfunction

    // ======================================================================
    // Next state
    always_comb begin
        s_d = s_q;
        // Pin synchronisers: a change counts once stages two and three agree
        s_d.en_sync = {s_q.en_sync[1:0], enable_i};
        if (s_q.en_sync[1] == s_q.en_sync[2]) begin
            s_d.en = s_q.en_sync[2];
        end
        s_d.lp_s1 = loop_path_enable_n_i;
        s_d.lp_s2 = s_q.lp_s1;
        s_d.lp_s3 = s_q.lp_s2;
        for (int i = 0; i < NUM_CH; i++) begin
            if (s_q.lp_s2[i] == s_q.lp_s3[i]) begin
                s_d.lp_pin_n[i] = s_q.lp_s3[i];
            end
        end

        // Read returns the pre-clear value
        // Unmapped numbers answer zero, never stale data
        s_d.rvalid = reg_rd_i;
        s_d.raddr  = reg_addr_i;
        if (rd_ev) begin
            s_d.rdata = s_q.ev_stat;
        end else if (rd_al) begin
            s_d.rdata = {11'h000, s_q.al_stat};
        end else begin
            s_d.rdata = 16'h0000;
        end

        s_d.ev_stat[`QLS_TXCOLL_LSB+:4]  = rc_flag(s_q.ev_stat[`QLS_TXCOLL_LSB+:4],
                                                   tx_fifo_coll_i, rd_ev, live);
        s_d.ev_stat[`QLS_DECERR_LSB+:4]  = rc_flag(s_q.ev_stat[`QLS_DECERR_LSB+:4],
                                                   decode_err_i, rd_ev, live);
        // Pass bits are active low in their set sense: error wins over re-arm
        s_d.ev_stat[`QLS_PRBS_LSB+:4]    = ~rc_flag(~s_q.ev_stat[`QLS_PRBS_LSB+:4],
                                                    prbs_err_i, rd_ev, live);
        s_d.ev_stat[`QLS_CARRIER_LSB+:4] = rc_flag(s_q.ev_stat[`QLS_CARRIER_LSB+:4],
                                                   carrier_absent_i, rd_ev, live);
        s_d.al_stat[`QLS_RXCOLL_LSB+:4]  = rc_flag(s_q.al_stat[`QLS_RXCOLL_LSB+:4],
                                                   rx_fifo_coll_i, rd_al, live);
        s_d.al_stat[`QLS_ALIGN_BIT]      = (live && align_seen_i) ||
                                           (s_q.al_stat[`QLS_ALIGN_BIT] && !rd_al);

        // Multifunction pins follow the selected source
        for (int i = 0; i < NUM_CH; i++) begin
            case (qls_mf_sel_t'(mf_sel_i[2*i+:2]))
                QLS_MF_IO_STD:  s_d.mf[i] = io_std_i;
                QLS_MF_COMMA:   s_d.mf[i] = comma_det_i[i];
                QLS_MF_CARRIER: s_d.mf[i] = s_q.ev_stat[`QLS_CARRIER_LSB+i];
                QLS_MF_PRBS:    s_d.mf[i] = s_q.ev_stat[`QLS_PRBS_LSB+i];
                default:        s_d.mf[i] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '{en_sync:  3'h0,
                     en:       1'b0,
                     lp_s1:    `QLS_LOOP_PIN_RST,
                     lp_s2:    `QLS_LOOP_PIN_RST,
                     lp_s3:    `QLS_LOOP_PIN_RST,
                     lp_pin_n: `QLS_LOOP_PIN_RST,
                     ev_stat:  `QLS_EVENT_RST,
                     al_stat:  `QLS_ALIGN_RST,
                     rdata:    16'h0000,
                     rvalid:   1'b0,
                     raddr:    5'h00,
                     mf:       4'h0};
        end else begin
            s_q <= s_d;
        end
    end

    // ======================================================================
    // Outputs
    assign reg_rdata_o  = s_q.rdata;
    assign reg_rvalid_o = s_q.rvalid;
    assign digital_en_o = s_q.en;
    // Floating parallel data reads high through the pad keeper
    assign rx_data_oe_o = s_q.en && !por_active;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            assign loopback_o[g] = !s_q.lp_pin_n[g] || cfg_loopback_i[g] ||
                                   global_loopback_i;
            assign tx_serial_oe_o[g] = s_q.en && !por_active && !loopback_o[g];
            assign rx_word_clock_en_o[g] = s_q.en && !por_active;
            // Pin keeps following its selected source while disabled; outputs float anyway
            assign multifunction_output_o[g] = s_q.mf[g];
        end
    endgenerate

    // ======================================================================
    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    tx_coll_set_a: assert property (live && tx_fifo_coll_i[0] |=>
        s_q.ev_stat[`QLS_TXCOLL_LSB])
        else $error("Tx FIFO collision not recorded");
    dec_err_set_a: assert property (live && decode_err_i[3] |=>
        s_q.ev_stat[`QLS_DECERR_LSB+3])
        else $error("Decode error not recorded");
    prbs_drop_a: assert property (live && prbs_err_i[1] |=>
        !s_q.ev_stat[`QLS_PRBS_LSB+1] ##1 ($past(rd_ev) || !s_q.ev_stat[`QLS_PRBS_LSB+1]))
        else $error("PRBS pass bit did not drop or recovered without read");
    carrier_set_a: assert property (live && carrier_absent_i[2] |=>
        s_q.ev_stat[`QLS_CARRIER_LSB+2])
        else $error("Carrier loss not recorded");
    align_set_a: assert property (live && align_seen_i |=>
        s_q.al_stat[`QLS_ALIGN_BIT])
        else $error("Alignment flag not set");
    rx_coll_set_a: assert property (live && rx_fifo_coll_i[1] && rd_al |=>
        s_q.al_stat[`QLS_RXCOLL_LSB+1])
        else $error("Rx FIFO collision lost on read");
    read_clear_a: assert property (rd_ev && !(live &&
        (tx_fifo_coll_i | decode_err_i | prbs_err_i | carrier_absent_i) != '0) |=>
        s_q.ev_stat == `QLS_EVENT_RST && reg_rdata_o == $past(s_q.ev_stat))
        else $error("Event status read did not clear");
    power_down_a: assert property (!s_q.en |->
        tx_serial_oe_o == '0 && !rx_data_oe_o)
        else $error("Outputs driven while disabled");
    loop_float_a: assert property ((loopback_o & tx_serial_oe_o) == '0)
        else $error("Serial output driven in loopback");
    loop_pin_a: assert property ($fell(s_q.lp_pin_n[0]) |-> loopback_o[0])
        else $error("Loopback pin ignored");
    por_hold_a: assert property (por_active |->
        rx_word_clock_en_o == '0 && !rx_data_oe_o)
        else $error("Outputs active during power-on reset");
    reserved_zero_a: assert property (reg_rvalid_o && s_q.raddr == `QLS_OFS_ALIGN_STATUS |->
        reg_rdata_o[15:5] == 11'h000)
        else $error("Reserved sync bits not zero");
    mf_carrier_a: assert property (mf_sel_i[1:0] == 2'h2 && $stable(mf_sel_i) |=>
        multifunction_output_o[0] == $past(s_q.ev_stat[`QLS_CARRIER_LSB]))
        else $error("Multifunction pin does not track carrier status");
    // Coincident event and clear: the event must survive
    event_wins_a: assert property (live && rd_ev && decode_err_i[1] |=>
        s_q.ev_stat[`QLS_DECERR_LSB+1])
        else $error("Decode error lost in its clearing read");
    pass_drop_wins_a: assert property (live && rd_ev && prbs_err_i[0] |=>
        !s_q.ev_stat[`QLS_PRBS_LSB])
        else $error("PRBS error lost in its re-arming read");
    align_wins_a: assert property (live && rd_al && align_seen_i |=>
        s_q.al_stat[`QLS_ALIGN_BIT])
        else $error("Alignment lost in its clearing read");
    sync_clear_a: assert property (rd_al && !(live &&
        (align_seen_i || rx_fifo_coll_i != '0)) |=>
        s_q.al_stat == `QLS_ALIGN_RST && reg_rdata_o == {11'h000, $past(s_q.al_stat)})
        else $error("Sync status read did not clear");
    read_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("Read strobe got no answer");
    read_pulse_a: assert property (!reg_rd_i |=> !reg_rvalid_o)
        else $error("Read answer without a strobe");
    unmapped_zero_a: assert property (reg_rd_i && !rd_ev && !rd_al |=>
        reg_rdata_o == 16'h0000)
        else $error("Unmapped register did not read zero");
    live_drive_a: assert property (live |->
        rx_data_oe_o && rx_word_clock_en_o == '1)
        else $error("Outputs idle after power-on reset");
    idle_ignore_a: assert property (!live && !rd_ev && !rd_al |=>
        $stable(s_q.ev_stat) && $stable(s_q.al_stat))
        else $error("Status changed while disabled");
    en_filter_a: assert property (s_q.en_sync[2] != s_q.en_sync[1] |=>
        $stable(s_q.en))
        else $error("Enable changed before its samples agreed");

    // ======================================================================
    // Per-channel checks; the single-channel ones above pin exact bits
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_chk
            tx_coll_ch_a: assert property (live && tx_fifo_coll_i[g] |=>
                s_q.ev_stat[`QLS_TXCOLL_LSB+g])
                else $error("Tx FIFO collision not recorded on a channel");
            dec_err_ch_a: assert property (live && decode_err_i[g] |=>
                s_q.ev_stat[`QLS_DECERR_LSB+g])
                else $error("Decode error not recorded on a channel");
            prbs_ch_a: assert property (live && prbs_err_i[g] |=>
                !s_q.ev_stat[`QLS_PRBS_LSB+g])
                else $error("PRBS pass bit did not drop on a channel");
            pass_rearm_a: assert property (rd_ev && !(live && prbs_err_i[g]) |=>
                s_q.ev_stat[`QLS_PRBS_LSB+g])
                else $error("PRBS pass bit not re-armed by a read");
            carrier_ch_a: assert property (live && carrier_absent_i[g] |=>
                s_q.ev_stat[`QLS_CARRIER_LSB+g])
                else $error("Carrier loss not recorded on a channel");
            rx_coll_ch_a: assert property (live && rx_fifo_coll_i[g] |=>
                s_q.al_stat[`QLS_RXCOLL_LSB+g])
                else $error("Rx FIFO collision not recorded on a channel");
            lp_filter_a: assert property (s_q.lp_s2[g] != s_q.lp_s3[g] |=>
                $stable(s_q.lp_pin_n[g]))
                else $error("Loopback pin changed before its samples agreed");
            tx_oe_live_a: assert property (live && !loopback_o[g] |->
                tx_serial_oe_o[g])
                else $error("Serial output floating outside loopback");
            loop_cfg_a: assert property (cfg_loopback_i[g] || global_loopback_i |->
                loopback_o[g])
                else $error("Loopback config bit ignored");
            mf_carrier_ch_a: assert property (mf_sel_i[2*g+:2] == 2'h2 |=>
                multifunction_output_o[g] == $past(s_q.ev_stat[`QLS_CARRIER_LSB+g]))
                else $error("Multifunction pin does not track carrier status");
            mf_prbs_a: assert property (mf_sel_i[2*g+:2] == 2'h3 |=>
                multifunction_output_o[g] == $past(s_q.ev_stat[`QLS_PRBS_LSB+g]))
                else $error("Multifunction pin does not track PRBS pass status");
        end
    endgenerate

    read_ev_c:  cover property (rd_ev && live && (tx_fifo_coll_i != '0));
    align_c:    cover property (live && align_seen_i ##[1:20] rd_al);
    loop_c:     cover property (live && loopback_o != '0);
    por_end_c:  cover property ($fell(por_active));
    mf_prbs_c:  cover property (mf_sel_i == 8'hff ##1 multifunction_output_o != '0);

endmodule // qls_ctrl

// [design/qls_consts.svh]
/*
 * Offsets, field positions, reset values and timing counts of the quad link
 * status and test-control block.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef QLS_CONSTS_SVH
`define QLS_CONSTS_SVH

// ==========================================================================
// Register offsets (management register numbers)
`define QLS_ADDR_W            5
`define QLS_OFS_EVENT_STATUS  5'h16
`define QLS_OFS_ALIGN_STATUS  5'h17

// ==========================================================================
// Field positions of channel_event_status
`define QLS_TXCOLL_LSB        12
`define QLS_DECERR_LSB        8
`define QLS_PRBS_LSB          4
`define QLS_CARRIER_LSB       0

// ==========================================================================
// Field positions of alignment_and_rx_fifo_status
`define QLS_RXCOLL_LSB        0
`define QLS_ALIGN_BIT         4

// ==========================================================================
// Reset values
`define QLS_EVENT_RST         16'h00f0
`define QLS_ALIGN_RST         5'h00
`define QLS_LOOP_PIN_RST      4'hf

// ==========================================================================
// Timing: power-on reset must end within this time (longest, rounds down)
`define QLS_CLK_PERIOD_NS     100
`define QLS_POR_TIME_NS       1000000
`define QLS_POR_CYCLES        (`QLS_POR_TIME_NS / `QLS_CLK_PERIOD_NS)

`endif

// [design/qls_pkg.sv]
/*
 * Types shared by the quad link status and test-control block.
 * Assumes qls_consts.svh is on the include path.
 */
package qls_pkg;
`include "qls_consts.svh"

    // ======================================================================
    // Multifunction pin source select, two config bits per channel
    typedef enum logic [1:0] {
        QLS_MF_IO_STD,
        QLS_MF_COMMA,
        QLS_MF_CARRIER,
        QLS_MF_PRBS
    } qls_mf_sel_t;

    // ======================================================================
    // Power-on reset sequencer
    typedef enum logic {
        QLS_POR_COUNT,
        QLS_POR_DONE
    } qls_por_phase_t;

    typedef struct packed {
        qls_por_phase_t phase;
        logic [31:0]    cnt;
    } qls_por_state_t;

    // ======================================================================
    // Main block state
    typedef struct packed {
        logic [2:0]  en_sync;
        logic        en;
        logic [3:0]  lp_s1;
        logic [3:0]  lp_s2;
        logic [3:0]  lp_s3;
        logic [3:0]  lp_pin_n;
        logic [15:0] ev_stat;
        logic [4:0]  al_stat;
        logic [15:0] rdata;
        logic        rvalid;
        logic [4:0]  raddr;
        logic [3:0]  mf;
    } qls_state_t;

endpackage

// [design/qls_por.sv]
/*
 * Power-on reset sequencer: holds por_active_o for a fixed count of
 * reference clock cycles after rst_i (power not valid) is released.
 * Assumes rst_i is asserted while supply power is not yet valid.
 */
`timescale 1ns/100ps
`include "qls_consts.svh"

module qls_por #(
    parameter int unsigned POR_CYCLES = `QLS_POR_CYCLES
) (
    input  wire logic sys_clk_i,    // Reference clock
    input  wire logic rst_i,        // Power not yet valid
    output logic      por_active_o  // High during power-on reset
);
    import qls_pkg::*;

    qls_por_state_t s_q;
    qls_por_state_t s_d;

    // ======================================================================
    // Sequencer
    always_comb begin
        s_d = s_q;
        case (s_q.phase)
            QLS_POR_COUNT: begin
                if (s_q.cnt == 32'(POR_CYCLES - 1)) begin
                    s_d.phase = QLS_POR_DONE;
                end else begin
                    s_d.cnt = s_q.cnt + 32'h1;
                end
            end
            QLS_POR_DONE: s_d.phase = QLS_POR_DONE;
            default:      s_d.phase = QLS_POR_COUNT;
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '{phase: QLS_POR_COUNT, cnt: 32'h0};
        end else begin
            s_q <= s_d;
        end
    end

    assign por_active_o = (s_q.phase == QLS_POR_COUNT);

    // ======================================================================
    // Checks
    por_length_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $fell(por_active_o) |-> $past(s_q.cnt) == 32'(POR_CYCLES - 1))
        else $error("Power-on reset ended at the wrong count");

endmodule // qls_por

// [dv/qls_mgmt_model.sv]
/*
 * Management bus controller model: issues one-cycle register read strobes.
 * Assumes the bench calls read from one process at a time.
 */
`timescale 1ns/100ps
`include "qls_consts.svh"

module qls_mgmt_model (
    input  wire logic                   sys_clk_i,  // Reference clock
    output logic                        reg_rd_o,   // Read strobe
    output logic [`QLS_ADDR_W-1:0]      reg_addr_o  // Register number
);
    initial begin
        reg_rd_o   = 1'b0;
        reg_addr_o = 5'h0a;
    end

    // ======================================================================
    // Read cycle, launched on the falling edge
    task automatic read(input logic [`QLS_ADDR_W-1:0] addr);
        @(negedge sys_clk_i);
        reg_rd_o   = 1'b1;
        reg_addr_o = addr;
        @(negedge sys_clk_i);
        reg_rd_o   = 1'b0;
        // Idle address is scrambled so a stale value never looks valid
        reg_addr_o = ~addr;
    endtask
endmodule // qls_mgmt_model

// [dv/test_quad_link_status_and_test_control.sv]
/*
 * Self-checking bench of the quad link status and test-control block.
 * Assumes qls_consts.svh on the include path and qls_pkg compiled first.
 */
`timescale 1ns/100ps
`include "qls_consts.svh"
`define QLS_CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module test_quad_link_status_and_test_control;
    import qls_pkg::*;
    localparam int unsigned POR = 8;
    logic        sys_clk_i = 1'b0, rst_i = 1'b1, enable_i = 1'b1, glb = 1'b0, io_std = 1'b0, align = 1'b0;
    logic [3:0]  lp_n = 4'hf, cfg = 4'h0, comma = 4'h0, txc = 4'h0, dec = 4'h0, prbs = 4'h0, car = 4'h0, rxc = 4'h0;
    logic [7:0]  mf_sel = 8'h00;
    logic        reg_rd, rvalid, den, rxoe;
    logic [4:0]  reg_addr, al;
    logic [15:0] rdata, ev, e_mon;
    logic [3:0]  lpo, txoe, wcen, mfo, m;
    logic [15:0] exp_q[$];
    int          n_mismatch = 0, n_tests = 0, cyc = 0, cnt;

    qls_mgmt_model i_mgmt (.sys_clk_i(sys_clk_i), .reg_rd_o(reg_rd), .reg_addr_o(reg_addr));
    qls_ctrl #(.POR_CYCLES(POR), .NUM_CH(4)) i_dut (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .enable_i(enable_i), .loop_path_enable_n_i(lp_n),
        .cfg_loopback_i(cfg), .global_loopback_i(glb), .mf_sel_i(mf_sel), .io_std_i(io_std),
        .comma_det_i(comma), .tx_fifo_coll_i(txc), .decode_err_i(dec), .prbs_err_i(prbs),
        .carrier_absent_i(car), .align_seen_i(align), .rx_fifo_coll_i(rxc), .reg_rd_i(reg_rd),
        .reg_addr_i(reg_addr), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .digital_en_o(den),
        .loopback_o(lpo), .tx_serial_oe_o(txoe), .rx_data_oe_o(rxoe), .rx_word_clock_en_o(wcen),
        .multifunction_output_o(mfo));

    always #50 sys_clk_i = ~sys_clk_i;

    // ======================================================================
    // Hang guard, well above the expected run of about 265 cycles
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            results();
        end
    end

    // ======================================================================
    // Read data monitor: oldest note against each answer
    always @(negedge sys_clk_i) begin
        if (rvalid === 1'b1) begin
            `QLS_CHK(exp_q.size() > 0, 1'b1)
            e_mon = exp_q.pop_front();
            `QLS_CHK(rdata, e_mon)
        end
    end

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic rd(input logic [4:0] a, input logic [15:0] x);
        exp_q.push_back(x);
        i_mgmt.read(a);
    endtask

    task automatic pulse(input int k, input logic [3:0] v);
        @(negedge sys_clk_i);
        case (k)
            0: txc = v;
            1: dec = v;
            2: prbs = v;
            3: car = v;
            4: rxc = v;
            default: align = v[0];
        endcase
        @(negedge sys_clk_i);
        {txc, dec, prbs, car, rxc, align} = '0;
    endtask

    // ======================================================================
    // Main sequence
    initial begin
        void'($urandom(14344));
        repeat (16) @(negedge sys_clk_i);
        `QLS_CHK({rxoe, wcen}, 5'h00)
        rst_i = 1'b0;
        cnt = 0;
        while (rxoe !== 1'b1 && cnt < 40) begin
            `QLS_CHK(wcen, 4'h0)
            @(negedge sys_clk_i);
            cnt++;
        end
        `QLS_CHK(cnt >= POR && cnt <= POR + 6, 1'b1)
        `QLS_CHK(den, 1'b1)
        `QLS_CHK(wcen, 4'hf)
        rd(5'h16, 16'h00f0);
        rd(5'h17, 16'h0000);
        rd(5'h00, 16'h0000);
        rd(5'h1f, 16'h0000);
        for (int k = 0; k < 12; k++) begin
            m = (k % 6 == 5) ? 4'h1 : 4'(($urandom % 15) + 1);
            ev = 16'h00f0;
            al = 5'h00;
            case (k % 6)
                0: ev[15:12] = m;
                1: ev[11:8] = m;
                2: ev[7:4] = ~m;
                3: ev[3:0] = m;
                4: al[3:0] = m;
                default: al[4] = 1'b1;
            endcase
            pulse(k % 6, m);
            rd(5'h16, ev);
            rd(5'h17, {11'h000, al});
            rd(5'h16, 16'h00f0);
            rd(5'h17, 16'h0000);
        end
        fork
            rd(5'h16, 16'h00f0);
            pulse(1, 4'h2);
        join
        rd(5'h16, 16'h02f0);
        fork
            rd(5'h16, 16'h00f0);
            pulse(2, 4'h1);
        join
        rd(5'h16, 16'h00e0);
        for (int j = 4; j < 6; j++) begin
            fork
                rd(5'h17, 16'h0000);
                pulse(j, 4'h3);
            join
            rd(5'h17, (j == 4) ? 16'h0003 : 16'h0010);
        end
        pulse(3, 4'h5);
        pulse(2, 4'h3);
        for (int s = 0; s < 4; s++) begin
            io_std = 1'($urandom);
            comma = 4'($urandom);
            mf_sel = {4{2'(s)}};
            repeat (3) @(negedge sys_clk_i);
            m = (s == 0) ? {4{io_std}} : (s == 1) ? comma : (s == 2) ? 4'h5 : 4'hc;
            `QLS_CHK(mfo, m)
        end
        rd(5'h16, 16'h00c5);
        for (int i = 0; i < 8; i++) begin
            lp_n = 4'($urandom);
            cfg = 4'($urandom);
            glb = ($urandom % 4 == 0);
            repeat (6) @(negedge sys_clk_i);
            m = ~lp_n | cfg | {4{glb}};
            `QLS_CHK(lpo, m)
            `QLS_CHK(txoe, ~m)
        end
        {lp_n, cfg, glb} = {4'hf, 4'h0, 1'b0};
        enable_i = 1'b0;
        repeat (6) @(negedge sys_clk_i);
        `QLS_CHK({den, rxoe, txoe}, 6'h00)
        pulse(0, 4'hf);
        enable_i = 1'b1;
        repeat (POR + 8) @(negedge sys_clk_i);
        `QLS_CHK({den, rxoe, txoe}, 6'h3f)
        rd(5'h16, 16'h00f0);
        repeat (4) @(negedge sys_clk_i);
        `QLS_CHK(exp_q.size(), 0)
        results();
    end
endmodule // test_quad_link_status_and_test_control
